// *** rtl/logic_cluster.sv ***
// Logic cluster of ten cells with its control generation and AXI4-Lite configuration slave
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps

module logic_cluster #(
	parameter int NUM_CELLS = logic_cluster_pkg::NUM_CELLS,
	parameter int NUM_EXT   = logic_cluster_pkg::NUM_EXT,
	parameter int ADDR_W    = 8
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr_i,
	input  wire logic                 s_axi_awvalid_i,
	output logic                      s_axi_awready_o,
	input  wire logic [31:0]          s_axi_wdata_i,
	input  wire logic [3:0]           s_axi_wstrb_i,
	input  wire logic                 s_axi_wvalid_i,
	output logic                      s_axi_wready_o,
	output logic [1:0]                s_axi_bresp_o,
	output logic                      s_axi_bvalid_o,
	input  wire logic                 s_axi_bready_i,
	input  wire logic [ADDR_W-1:0]    s_axi_araddr_i,
	input  wire logic                 s_axi_arvalid_i,
	output logic                      s_axi_arready_o,
	output logic [31:0]               s_axi_rdata_o,
	output logic [1:0]                s_axi_rresp_o,
	output logic                      s_axi_rvalid_o,
	input  wire logic                 s_axi_rready_i,
	input  wire logic [3:0]           col_clk_i,
	input  wire logic [NUM_EXT-1:0]   ext_i,
	input  wire logic [NUM_CELLS-1:0] left_link_i,
	input  wire logic [NUM_CELLS-1:0] right_link_i,
	output logic [NUM_CELLS-1:0]      route_a_o,
	output logic [NUM_CELLS-1:0]      route_b_o,
	output logic                      carry_o
);

	localparam int NLINES = NUM_EXT + 3 * NUM_CELLS;
	localparam int NIN    = logic_cluster_pkg::NUM_COL + NUM_EXT + 2 * NUM_CELLS;
	localparam int IDX_CLK   = 32'(logic_cluster_pkg::CTRL_CLK) / 4;
	localparam int IDX_ASYNC = 32'(logic_cluster_pkg::CTRL_ASYNC) / 4;
	localparam int IDX_MISC  = 32'(logic_cluster_pkg::CTRL_MISC) / 4;
	localparam int IDX_STAT  = 32'(logic_cluster_pkg::STATUS) / 4;
	localparam int IDX_BAD   = 255;

	if (NUM_CELLS < 1 || NUM_CELLS > 10 || NLINES > 63 || ADDR_W < 7) begin : g_bad_params
		$error("logic_cluster: parameters outside the supported range");
	end

	// Any of the local lines, or zero for an unused selector
	function automatic logic pick(input logic [NLINES-1:0] l, input logic [5:0] s);
		pick = 1'b0;
		if (32'(s) < NLINES) begin
			pick = l[s];
		end
	endfunction

	function automatic int reg_index(input logic [ADDR_W-1:0] a);
		int idx;
		idx = 32'(a) / 4;
		if (a[1:0] != 2'b00 || idx > IDX_STAT || (idx >= 2 * NUM_CELLS && idx < IDX_CLK)) begin
			idx = IDX_BAD;
		end
		return idx;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Pin inputs: two flops before any logic reads them
	logic [NIN-1:0] sync1_q;
	logic [NIN-1:0] sync2_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {right_link_i, left_link_i, ext_i, col_clk_i};
			sync2_q <= sync1_q;
		end
	end

	logic [3:0]           col_s;
	logic [NUM_EXT-1:0]   ext_s;
	logic [NUM_CELLS-1:0] left_s;
	logic [NUM_CELLS-1:0] right_s;
	logic [NUM_CELLS-1:0] fb_vec;
	logic [NLINES-1:0]    lines;

	assign {right_s, left_s, ext_s, col_s} = sync2_q;
	assign lines = {right_s, left_s, fb_vec, ext_s};

	// Configuration storage
	logic [31:0]                    cfg_q [NUM_CELLS];
	logic [31:0]                    sel_q [NUM_CELLS];
	logic_cluster_pkg::clk_ctrl_s   clk_ctrl_q;
	logic_cluster_pkg::async_ctrl_s async_q;
	logic_cluster_pkg::misc_ctrl_s  misc_q;
	logic                           init_q;

	// Cluster-wide controls
	logic [1:0] clk_lvl;
	logic [1:0] clk_prev_q;
	logic [1:0] clk_edge;
	logic [1:0] ena;
	logic [1:0] aclr;
	logic       sclr;
	logic       sload;
	logic       aload;
	logic       addnsub;

	always_comb begin
		logic_cluster_pkg::clk_src_s src;
		src = clk_ctrl_q.clk0;
		for (int k = 0; k < 2; k++) begin
			src = (k == 0) ? clk_ctrl_q.clk0 : clk_ctrl_q.clk1;
			clk_lvl[k] = (src.use_loc ? pick(lines, src.loc) : col_s[src.col]) ^ src.falling;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_prev_q <= '0;
		end else begin
			clk_prev_q <= clk_lvl;
		end
	end

	assign clk_edge = clk_lvl & ~clk_prev_q;
	// Enable selector at SEL_NONE reads as always on; any other unused selector reads as off
	assign ena[0]  = (misc_q.ena0 == logic_cluster_pkg::SEL_NONE) | pick(lines, misc_q.ena0);
	assign ena[1]  = (misc_q.ena1 == logic_cluster_pkg::SEL_NONE) | pick(lines, misc_q.ena1);
	assign aclr[0] = pick(lines, async_q.aclr0);
	assign aclr[1] = pick(lines, async_q.aclr1);
	assign sclr    = pick(lines, async_q.sclr);
	assign sload   = pick(lines, async_q.sload);
	assign aload   = pick(lines, async_q.aload);
	assign addnsub = pick(lines, misc_q.addnsub);

	// Cells
	logic [NUM_CELLS-1:0] lut_out;
	logic [NUM_CELLS-1:0] cout;
	logic [NUM_CELLS-1:0] q_vec;
	logic [NUM_CELLS-1:0] lut_prev;
	logic [NUM_CELLS-1:0] q_prev;
	logic [NUM_CELLS-1:0] cin;

	if (NUM_CELLS > 1) begin : g_chain
		assign lut_prev = {lut_out[NUM_CELLS-2:0], 1'b0};
		assign q_prev   = {q_vec[NUM_CELLS-2:0], 1'b0};
		assign cin      = {cout[NUM_CELLS-2:0], addnsub};
	end else begin : g_single
		assign lut_prev = 1'b0;
		assign q_prev   = 1'b0;
		assign cin      = addnsub;
	end

	for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
		logic_cluster_pkg::cell_cfg_s cfg;
		logic_cluster_pkg::cell_sel_s sel;
		logic                         a;
		logic                         b;
		logic                         c;
		logic                         d;
		logic                         bx;
		logic                         tab;
		logic                         din;
		logic                         q_q;
		logic                         ra_q;
		logic                         rb_q;
		logic                         lo_q;

		assign cfg = logic_cluster_pkg::cell_cfg_s'(cfg_q[i]);
		assign sel = logic_cluster_pkg::cell_sel_s'(sel_q[i]);
		assign a   = cfg.lut_chain ? lut_prev[i] : pick(lines, sel.a);
		assign b   = pick(lines, sel.b);
		assign c   = cfg.feedback ? q_q : pick(lines, sel.c);
		assign d   = pick(lines, sel.d);
		assign tab = cfg.lut[{d, c, b, a}];
		// B inverted for subtraction, carry-in of the first cell is the select itself
		assign bx  = b ^ addnsub;
		assign lut_out[i] = cfg.arith ? (a ^ bx ^ cin[i]) : tab;
		assign cout[i]    = (a & bx) | (cin[i] & (a ^ bx));
		assign din        = cfg.reg_chain ? q_prev[i] : lut_out[i];

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				q_q <= 1'b0;
			end else if (init_q) begin
				q_q <= cfg.pu_high;
			end else if (cfg.use_aclr && aclr[cfg.aclr_sel]) begin
				q_q <= 1'b0;
			end else if (cfg.use_aload && aload) begin
				q_q <= d;
			end else if (clk_edge[cfg.clk_sel] && ena[cfg.clk_sel]) begin
				if (cfg.use_sync && sclr) begin
					q_q <= 1'b0;
				end else if (cfg.use_sync && sload) begin
					q_q <= c;
				end else begin
					case (cfg.mode)
						logic_cluster_pkg::REG_D:  q_q <= din;
						logic_cluster_pkg::REG_T:  q_q <= q_q ^ din;
						logic_cluster_pkg::REG_JK: q_q <= q_q ? ~c : din;
						logic_cluster_pkg::REG_SR: q_q <= din | (q_q & ~c);
						default:                   q_q <= q_q;
					endcase
				end
			end
		end

		// Each output picks register or table on its own
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				ra_q <= 1'b0;
				rb_q <= 1'b0;
				lo_q <= 1'b0;
			end else begin
				ra_q <= cfg.out_sel[0] ? q_q : lut_out[i];
				rb_q <= cfg.out_sel[1] ? q_q : lut_out[i];
				lo_q <= cfg.out_sel[2] ? q_q : lut_out[i];
			end
		end

		assign q_vec[i]     = q_q;
		assign route_a_o[i] = ra_q;
		assign route_b_o[i] = rb_q;
		assign fb_vec[i]    = lo_q;
	end

	logic carry_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			carry_q <= 1'b0;
		end else begin
			carry_q <= cout[NUM_CELLS-1];
		end
	end

	assign carry_o = carry_q;

	// AXI4-Lite write side; address and data may arrive in either order
	logic [ADDR_W-1:0] awaddr_q;
	logic              aw_full_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              w_full_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              do_wr;
	int                widx;

	assign s_axi_awready_o = ~aw_full_q & ~bvalid_q;
	assign s_axi_wready_o  = ~w_full_q & ~bvalid_q;
	assign s_axi_bvalid_o  = bvalid_q;
	assign s_axi_bresp_o   = bresp_q;
	assign do_wr           = aw_full_q & w_full_q;
	assign widx            = reg_index(awaddr_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			awaddr_q  <= '0;
			aw_full_q <= 1'b0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
			w_full_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= logic_cluster_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				awaddr_q  <= s_axi_awaddr_i;
				aw_full_q <= 1'b1;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				wdata_q  <= s_axi_wdata_i;
				wstrb_q  <= s_axi_wstrb_i;
				w_full_q <= 1'b1;
			end
			if (do_wr) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (widx == IDX_BAD) ? logic_cluster_pkg::RESP_SLVERR : logic_cluster_pkg::RESP_OKAY;
			end else if (bvalid_q && s_axi_bready_i) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int n = 0; n < NUM_CELLS; n++) begin
				cfg_q[n] <= logic_cluster_pkg::CFG_RESET;
				sel_q[n] <= logic_cluster_pkg::SEL_RESET;
			end
			clk_ctrl_q <= logic_cluster_pkg::CLK_RESET;
			async_q    <= logic_cluster_pkg::ASYNC_RESET;
			misc_q     <= logic_cluster_pkg::MISC_RESET;
		end else if (do_wr) begin
			for (int n = 0; n < NUM_CELLS; n++) begin
				if (widx == 2 * n) begin
					cfg_q[n] <= merge(cfg_q[n], wdata_q, wstrb_q);
				end
				if (widx == 2 * n + 1) begin
					sel_q[n] <= merge(sel_q[n], wdata_q, wstrb_q);
				end
			end
			// Init bit is a strobe and never stored
			if (widx == IDX_CLK) begin
				clk_ctrl_q <= merge(clk_ctrl_q, wdata_q, wstrb_q) & 32'h7fff_ffff;
			end
			if (widx == IDX_ASYNC) begin
				async_q <= merge(async_q, wdata_q, wstrb_q);
			end
			if (widx == IDX_MISC) begin
				misc_q <= merge(misc_q, wdata_q, wstrb_q);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			init_q <= 1'b0;
		end else begin
			init_q <= do_wr && widx == IDX_CLK && wstrb_q[3] && wdata_q[31];
		end
	end

	// AXI4-Lite read side, one cycle from address to data
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [31:0] rd_word;
	int          ridx;

	assign s_axi_arready_o = ~rvalid_q;
	assign s_axi_rvalid_o  = rvalid_q;
	assign s_axi_rdata_o   = rdata_q;
	assign s_axi_rresp_o   = rresp_q;
	assign ridx            = reg_index(s_axi_araddr_i);

	always_comb begin
		rd_word = '0;
		for (int n = 0; n < NUM_CELLS; n++) begin
			if (ridx == 2 * n) begin
				rd_word = cfg_q[n];
			end
			if (ridx == 2 * n + 1) begin
				rd_word = sel_q[n];
			end
		end
		if (ridx == IDX_CLK) begin
			rd_word = clk_ctrl_q;
		end
		if (ridx == IDX_ASYNC) begin
			rd_word = async_q;
		end
		if (ridx == IDX_MISC) begin
			rd_word = misc_q;
		end
		if (ridx == IDX_STAT) begin
			rd_word = 32'({carry_q, q_vec});
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= logic_cluster_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= (ridx == IDX_BAD) ? logic_cluster_pkg::RESP_SLVERR : logic_cluster_pkg::RESP_OKAY;
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule

// *** rtl/logic_cluster_pkg.sv ***
// Constants, register map and carrier types of the logic cluster
package logic_cluster_pkg;

	localparam int NUM_CELLS = 10;
	localparam int NUM_EXT   = 26;
	localparam int NUM_COL   = 4;
	localparam int SEL_W     = 6;

	// Byte addresses on the register bus
	localparam logic [7:0] CELL_BASE  = 8'h00;
	localparam logic [7:0] CELL_STEP  = 8'h08;
	localparam logic [7:0] CTRL_CLK   = 8'h50;
	localparam logic [7:0] CTRL_ASYNC = 8'h54;
	localparam logic [7:0] CTRL_MISC  = 8'h58;
	localparam logic [7:0] STATUS     = 8'h5c;

	localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
	localparam logic [31:0] SEL_RESET   = 32'hffff_ffff;
	localparam logic [31:0] CLK_RESET   = 32'h0000_0000;
	localparam logic [31:0] ASYNC_RESET = 32'hffff_ffff;
	localparam logic [31:0] MISC_RESET  = 32'h0003_ffff;

	// Selector value that picks no local line
	localparam logic [SEL_W-1:0] SEL_NONE = 6'h3f;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		REG_D  = 2'b00,
		REG_T  = 2'b01,
		REG_JK = 2'b10,
		REG_SR = 2'b11
	} reg_mode_e;

	typedef struct packed {
		logic        spare;
		logic        use_sync;
		logic        use_aload;
		logic        use_aclr;
		logic        aclr_sel;
		logic        clk_sel;
		logic        pu_high;
		logic        arith;
		logic [2:0]  out_sel;
		logic        feedback;
		logic        reg_chain;
		logic        lut_chain;
		reg_mode_e   mode;
		logic [15:0] lut;
	} cell_cfg_s;

	typedef struct packed {
		logic [7:0]       spare;
		logic [SEL_W-1:0] d;
		logic [SEL_W-1:0] c;
		logic [SEL_W-1:0] b;
		logic [SEL_W-1:0] a;
	} cell_sel_s;

	typedef struct packed {
		logic [SEL_W-1:0] loc;
		logic             falling;
		logic             use_loc;
		logic [1:0]       col;
	} clk_src_s;

	typedef struct packed {
		logic        init;
		logic [10:0] spare;
		clk_src_s    clk1;
		clk_src_s    clk0;
	} clk_ctrl_s;

	typedef struct packed {
		logic [1:0]       spare;
		logic [SEL_W-1:0] sload;
		logic [SEL_W-1:0] aload;
		logic [SEL_W-1:0] sclr;
		logic [SEL_W-1:0] aclr1;
		logic [SEL_W-1:0] aclr0;
	} async_ctrl_s;

	typedef struct packed {
		logic [13:0]      spare;
		logic [SEL_W-1:0] ena1;
		logic [SEL_W-1:0] ena0;
		logic [SEL_W-1:0] addnsub;
	} misc_ctrl_s;

endpackage

// *** rtl/unused.sv ***
// Intentionally empty
`timescale 1ns/10ps

// *** dv/logic_cluster_props.sv ***
// Bus handshake and reset checks bound to the logic cluster
`timescale 1ns/10ps
module logic_cluster_props #(
	parameter int NUM_CELLS = 10
) (
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire logic                 s_axi_awvalid_i,
	input wire logic                 s_axi_awready_o,
	input wire logic                 s_axi_wvalid_i,
	input wire logic                 s_axi_wready_o,
	input wire logic [1:0]           s_axi_bresp_o,
	input wire logic                 s_axi_bvalid_o,
	input wire logic                 s_axi_bready_i,
	input wire logic                 s_axi_arvalid_i,
	input wire logic                 s_axi_arready_o,
	input wire logic [31:0]          s_axi_rdata_o,
	input wire logic [1:0]           s_axi_rresp_o,
	input wire logic                 s_axi_rvalid_o,
	input wire logic                 s_axi_rready_i,
	input wire logic [NUM_CELLS-1:0] route_a_o,
	input wire logic [NUM_CELLS-1:0] route_b_o,
	input wire logic                 carry_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped early");
	a_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)
		&& $stable(s_axi_rresp_o))
		else $error("read response dropped early");
	a_w_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
		|=> ##1 s_axi_bvalid_o)
		else $error("write response late");
	a_r_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read response late");
	a_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read address taken while busy");
	a_aw_refused: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while response pending");
	a_b_release: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write response not released");
	a_r_release: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
		else $error("read response not released");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !s_axi_bvalid_o && !s_axi_rvalid_o
		&& route_a_o == '0 && route_b_o == '0 && !carry_o)
		else $error("outputs not low after reset");

	c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
	c_slverr: cover property (s_axi_rvalid_o && s_axi_rready_i && s_axi_rresp_o == 2'h2);
	c_carry: cover property ($rose(carry_o));
	c_split: cover property (route_a_o != route_b_o);
endmodule

bind logic_cluster logic_cluster_props #(.NUM_CELLS(NUM_CELLS)) logic_cluster_props_i (.*);

// *** dv/fabric_model.sv ***
// Surrounding fabric: column clock pulses and neighbour link levels
`timescale 1ns/10ps
module fabric_model (
	input  wire logic        clk_i,
	input  wire logic        pulse_i,
	input  wire logic [19:0] link_i,
	output logic [3:0]       col_clk_o,
	output logic [9:0]       left_o,
	output logic [9:0]       right_o
);
	logic [3:0] cnt_q = 4'h0;

	// Long phases so the two-flop sync sees each level
	always_ff @(posedge clk_i) begin
		if (pulse_i) begin
			cnt_q <= 4'h8;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end

	// Clock stands low between pulses
	assign col_clk_o = {3'h0, cnt_q > 4'h4};
	assign left_o    = link_i[9:0];
	assign right_o   = link_i[19:10];
endmodule

// *** dv/tb_logic_cluster.sv ***
// Self-checking bench for the logic cluster
`timescale 1ns/10ps
module tb_logic_cluster;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  s_axi_awaddr_i = 8'h00;
	logic [7:0]  s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0]  s_axi_wstrb_i = 4'hf;
	logic        s_axi_awvalid_i = 1'b0;
	logic        s_axi_wvalid_i = 1'b0;
	logic        s_axi_bready_i = 1'b0;
	logic        s_axi_arvalid_i = 1'b0;
	logic        s_axi_rready_i = 1'b0;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, carry_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
	logic [31:0] s_axi_rdata_o, data;
	logic [25:0] ext_i = 26'h0;
	logic [9:0]  left_link_i, right_link_i, route_a_o, route_b_o;
	logic [3:0]  col_clk_i;
	logic [19:0] link = 20'h0;
	logic        pulse = 1'b0;
	int          errors = 0;
	int          n_tests = 0;
	int          cycles = 0;

	always #25 clk_i = ~clk_i;

	logic_cluster logic_cluster_i (.*);
	fabric_model fabric_model_i (.clk_i, .pulse_i(pulse), .link_i(link), .col_clk_o(col_clk_i),
		.left_o(left_link_i), .right_o(right_link_i));

	task automatic print_verdict();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta;
		logic tw;
		ta = 1'b0;
		tw = 1'b0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge clk_i);
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				ta = 1'b1;
				s_axi_awvalid_i <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				tw = 1'b1;
				s_axi_wvalid_i <= 1'b0;
			end
		end
		// Late ready, so a waiting response is exercised
		do @(posedge clk_i); while (!s_axi_bvalid_o);
		s_axi_bready_i <= 1'b1;
		@(posedge clk_i);
		resp = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		do @(posedge clk_i); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge clk_i); while (!s_axi_rvalid_o);
		s_axi_rready_i <= 1'b1;
		@(posedge clk_i);
		data = s_axi_rdata_o;
		resp = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
	endtask

	function automatic logic [7:0] cfg_a(input int n);
		return logic_cluster_pkg::CELL_BASE + logic_cluster_pkg::CELL_STEP * 8'(n);
	endfunction

	function automatic logic [31:0] sel(input logic [5:0] a, b, c, d);
		return {8'h00, d, c, b, a};
	endfunction

	task automatic clk_pulse();
		pulse <= 1'b1;
		@(posedge clk_i);
		pulse <= 1'b0;
		repeat (14) @(posedge clk_i);
	endtask

	task automatic t_regs();
		rd(logic_cluster_pkg::CTRL_MISC);
		chk(data, logic_cluster_pkg::MISC_RESET);
		rd(logic_cluster_pkg::CTRL_ASYNC);
		chk(data, logic_cluster_pkg::ASYNC_RESET);
		rd(cfg_a(9) + 8'h04);
		chk(data, logic_cluster_pkg::SEL_RESET);
		rd(cfg_a(9));
		chk(data, logic_cluster_pkg::CFG_RESET);
		rd(8'h60);
		chk(data, 32'h0);
		chk(resp, logic_cluster_pkg::RESP_SLVERR);
		wr(8'h61, 32'h1);
		chk(resp, logic_cluster_pkg::RESP_SLVERR);
		wr(cfg_a(3), 32'h00aa_5555);
		rd(cfg_a(3));
		chk(data, 32'h00aa_5555);
	endtask

	// Table walk with inputs from both neighbour links and two row lines
	task automatic t_lut();
		logic [15:0] lut = 16'h6ac5;
		wr(cfg_a(0) + 8'h04, sel(6'd36, 6'd46, 6'd0, 6'd1));
		wr(cfg_a(0), {16'h0, lut});
		for (int i = 0; i < 16; i++) begin
			link <= {9'h0, i[1], 9'h0, i[0]};
			ext_i <= {24'h0, i[3], i[2]};
			repeat (6) @(posedge clk_i);
			chk(route_a_o[0], lut[i]);
			chk(route_b_o[0], lut[i]);
		end
	endtask

	// Cell 0 register on route b, table on route a; cell 1 shifts from cell 0
	task automatic t_reg();
		logic [25:0] st [3] = '{26'h0c, 26'h08, 26'h04};
		logic [1:0] eb [3] = '{2'b01, 2'b10, 2'b10};
		logic [1:0] ea [3] = '{2'b01, 2'b10, 2'b11};
		wr(cfg_a(0) + 8'h04, sel(6'd2, 6'h3f, 6'h3f, 6'h3f));
		wr(cfg_a(0), 32'h0040_aaaa);
		wr(cfg_a(1), 32'h00e8_0000);
		wr(logic_cluster_pkg::CTRL_MISC, {14'h0, 6'h3f, 6'd3, 6'h3f});
		for (int i = 0; i < 3; i++) begin
			ext_i <= st[i];
			clk_pulse();
			chk(route_b_o[1:0], eb[i]);
			chk(route_a_o[1:0], ea[i]);
		end
	endtask

	task automatic t_add();
		logic [9:0] va [4] = '{10'h155, 10'h3ff, 10'h005, 10'h200};
		logic [9:0] vb [4] = '{10'h0ab, 10'h001, 10'h009, 10'h100};
		logic [10:0] e;
		for (int n = 0; n < 10; n++) begin
			wr(cfg_a(n), 32'h0100_0000);
			wr(cfg_a(n) + 8'h04, sel(6'(n), 6'(n + 10), 6'h3f, 6'h3f));
		end
		wr(logic_cluster_pkg::CTRL_MISC, {14'h0, 6'h3f, 6'h3f, 6'd20});
		for (int i = 0; i < 4; i++) begin
			ext_i <= {5'h0, i[1], vb[i], va[i]};
			e = {1'b0, va[i]} + {1'b0, vb[i] ^ {10{i[1]}}} + 11'(i[1]);
			repeat (6) @(posedge clk_i);
			chk(route_a_o, e[9:0]);
			chk(carry_o, e[10]);
		end
	endtask

	task automatic t_async();
		logic [25:0] st [3] = '{26'h40_0000, 26'hc0_0000, 26'he0_0000};
		wr(logic_cluster_pkg::CTRL_ASYNC, {2'h0, 6'h3f, 6'd22, 6'h3f, 6'h3f, 6'd21});
		wr(cfg_a(2) + 8'h04, sel(6'h3f, 6'h3f, 6'h3f, 6'd23));
		wr(cfg_a(2), 32'h3200_0000);
		ext_i <= 26'h0;
		wr(logic_cluster_pkg::CTRL_CLK, 32'h8000_0000);
		rd(logic_cluster_pkg::STATUS);
		chk(data[9:0], 10'h004);
		for (int i = 0; i < 3; i++) begin
			ext_i <= st[i];
			repeat (6) @(posedge clk_i);
			rd(logic_cluster_pkg::STATUS);
			chk(data[2], i == 1);
		end
	endtask

	// Table chain into cell 1; cell 2 toggles through its own feedback, sync clear blocks one edge
	task automatic t_chain();
		wr(logic_cluster_pkg::CTRL_ASYNC, {2'h0, 6'h3f, 6'h3f, 6'd24, 6'h3f, 6'h3f});
		wr(cfg_a(0) + 8'h04, sel(6'd0, 6'h3f, 6'h3f, 6'h3f));
		wr(cfg_a(0), 32'h0000_aaaa);
		wr(cfg_a(1), 32'h0004_aaaa);
		wr(cfg_a(2), 32'h4050_0f0f);
		ext_i <= 26'h100_0001;
		clk_pulse();
		chk(route_a_o[1], 1'b1);
		chk(route_b_o[2], 1'b0);
		ext_i <= 26'h0;
		clk_pulse();
		chk(route_a_o[1], 1'b0);
		chk(route_b_o[2], 1'b1);
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			print_verdict();
		end
	end

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_lut();
		t_reg();
		t_add();
		t_async();
		t_chain();
		print_verdict();
	end
endmodule
